// ==== hdl/ect_pkg.sv ====
`default_nettype none

package ect_pkg;

    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_COUNTER  = 8'h00;
    localparam logic [7:0]  ADDR_MODE     = 8'h04;
    localparam logic [7:0]  ADDR_RUN      = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] MODE_RESET    = 16'h0000;
    localparam logic [4:0]  RUN_RESET     = 5'h00;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0] COUNT_MIN     = 16'h0000;
    localparam logic [15:0] MODE_WR_MASK  = 16'h1FFF;
    localparam int          RUN_WIDTH     = 5;

    // ------------------------------------------------------------
    // count source select and status bit positions
    // ------------------------------------------------------------
    localparam logic [1:0]  SRC_PIN       = 2'h0;
    localparam logic [1:0]  SRC_TIMER_B   = 2'h1;
    localparam logic [1:0]  SRC_PREV      = 2'h2;
    localparam logic [1:0]  SRC_NEXT      = 2'h3;
    localparam int          STAT_AUX_IN   = 0;
    localparam int          STAT_PULSE    = 1;
    localparam int          STAT_COUNTING = 2;
    localparam int          STAT_INDEX    = 3;

    // layout of channel_mode_reg, msb first
    typedef struct packed {
        logic [2:0] rsvd;
        logic       gpio_data;
        logic       gpio_out;
        logic       idx_rise;
        logic       index_reset_enable;
        logic       quad;
        logic       two_phase_enable;
        logic       pulse_en;
        logic       free_run;
        logic       sw_up;
        logic       dir_ext;
        logic       edge_rise;
        logic [1:0] src;
    } ect_mode_t;

    // gray along stop -> armed -> counting
    typedef enum logic [1:0] {
        ST_STOP  = 2'b00,
        ST_ARMED = 2'b01,
        ST_COUNT = 2'b11
    } ect_state_t;

endpackage : ect_pkg

`default_nettype wire

// ==== hdl/ect_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ect_top #(
    parameter int CHANNEL = 3
) (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        count_input_pin_i,
    input  wire logic        aux_io_pin_i,
    output logic             aux_io_pin_o,
    output logic             aux_io_pin_oe_n_o,
    input  wire logic        index_input_pin_i,
    input  wire logic        timer_b_ovf_i,
    input  wire logic        prev_ovf_i,
    input  wire logic        next_ovf_i,
    output logic             ovf_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // registers and edge detection
    // ------------------------------------------------------------
    logic [15:0]         counter_reload_reg, reload_reg, counter_next;
    ect_pkg::ect_mode_t  channel_mode_reg;
    logic [4:0]          run_control_reg;
    ect_pkg::ect_state_t state_reg, state_next;
    logic                pulse_reg, pulse_next;
    logic                quad_up_reg, quad_up_next;
    logic                index_pend_reg, index_hit;
    logic                cin_reg, aux_reg, idx_reg;
    logic                run, cin_rise, cin_fall, aux_edge, idx_edge;
    logic                tp_ok, tp_quad, ev_raw, ev, up, wrap;
    logic                wr_cnt, load_both;

    assign run      = run_control_reg[CHANNEL];
    assign cin_rise = count_input_pin_i & ~cin_reg;
    assign cin_fall = ~count_input_pin_i & cin_reg;
    assign aux_edge = aux_io_pin_i ^ aux_reg;
    assign idx_edge = channel_mode_reg.idx_rise ?
                      (index_input_pin_i & ~idx_reg) :
                      (~index_input_pin_i & idx_reg);
    assign wr_cnt   = wr_i & (addr_i == ect_pkg::ADDR_COUNTER);

    // two-phase only exists on channels two to four
    assign tp_ok   = channel_mode_reg.two_phase_enable &
                     (CHANNEL >= 2) & (CHANNEL <= 4);
    assign tp_quad = (CHANNEL == 4) |
                     ((CHANNEL == 3) & channel_mode_reg.quad);
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cin_reg <= 1'b0;
            aux_reg <= 1'b0;
            idx_reg <= 1'b0;
        end
        else
        begin
            cin_reg <= count_input_pin_i;
            aux_reg <= aux_io_pin_i;
            idx_reg <= index_input_pin_i;
        end
    end

    // ------------------------------------------------------------
    // count event and direction
    // ------------------------------------------------------------
    always_comb
    begin
        quad_up_next = quad_up_reg;
        ev_raw       = 1'b0;
        up           = 1'b0;
        if (tp_ok && tp_quad)
        begin
            // direction latched at count edges seen with aux high
            if (aux_io_pin_i && cin_rise)
                quad_up_next = 1'b1;
            else if (aux_io_pin_i && cin_fall)
                quad_up_next = 1'b0;
            ev_raw = cin_rise | cin_fall | aux_edge;
            up     = quad_up_next;
        end
        else if (tp_ok)
        begin
            ev_raw = aux_io_pin_i & (cin_rise | cin_fall);
            up     = cin_rise;
        end
        else
        begin
            case (channel_mode_reg.src)
                ect_pkg::SRC_PIN:
                    ev_raw = channel_mode_reg.edge_rise ?
                             cin_rise : cin_fall;
                ect_pkg::SRC_TIMER_B: ev_raw = timer_b_ovf_i;
                ect_pkg::SRC_PREV:    ev_raw = prev_ovf_i;
                ect_pkg::SRC_NEXT:    ev_raw = next_ovf_i;
                default:              ev_raw = 1'b0;
            endcase
            up = channel_mode_reg.dir_ext ?
                 aux_io_pin_i : channel_mode_reg.sw_up;
        end
    end

    // write with loading wins over a same-cycle event
    assign load_both = wr_cnt & (state_reg != ect_pkg::ST_COUNT);
    assign ev        = ev_raw & run & ~load_both;
    assign index_hit = ev & index_pend_reg;
    assign wrap      = ev & ~index_hit &
                       (up ? (counter_reload_reg == ect_pkg::COUNT_MAX)
                           : (counter_reload_reg == ect_pkg::COUNT_MIN));

    // ------------------------------------------------------------
    // counter, reload and start state
    // ------------------------------------------------------------
    always_comb
    begin
        counter_next = counter_reload_reg;
        if (load_both)
            counter_next = wdata_i;
        else if (index_hit)
            counter_next = ect_pkg::COUNT_MIN;
        else if (wrap && !channel_mode_reg.free_run)
            counter_next = reload_reg;
        else if (ev && up)
            counter_next = counter_reload_reg + 16'h0001;
        else if (ev)
            counter_next = counter_reload_reg - 16'h0001;
    end

    always_comb
    begin
        case (state_reg)
            ect_pkg::ST_STOP:
                state_next = run ? ect_pkg::ST_ARMED : ect_pkg::ST_STOP;
            ect_pkg::ST_ARMED:
                state_next = !run ? ect_pkg::ST_STOP :
                             ev ? ect_pkg::ST_COUNT : ect_pkg::ST_ARMED;
            ect_pkg::ST_COUNT:
                state_next = run ? ect_pkg::ST_COUNT : ect_pkg::ST_STOP;
            default:
                state_next = ect_pkg::ST_STOP;
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            counter_reload_reg <= ect_pkg::COUNT_RESET;
            state_reg          <= ect_pkg::ST_STOP;
            quad_up_reg        <= 1'b0;
        end
        else
        begin
            counter_reload_reg <= counter_next;
            state_reg          <= state_next;
            quad_up_reg        <= quad_up_next;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            reload_reg <= ect_pkg::COUNT_RESET;
        else if (wr_cnt)
            reload_reg <= wdata_i;
    end
    // a new index edge beats the consuming event
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            index_pend_reg <= 1'b0;
        else if ((CHANNEL == 3) && tp_ok &&
                 channel_mode_reg.index_reset_enable && idx_edge)
            index_pend_reg <= 1'b1;
        else if (ev || !channel_mode_reg.index_reset_enable)
            index_pend_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // configuration registers and read port
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            channel_mode_reg <= ect_pkg::MODE_RESET;
            run_control_reg  <= ect_pkg::RUN_RESET;
        end
        else
        begin
            if (wr_i && addr_i == ect_pkg::ADDR_MODE)
                channel_mode_reg <= wdata_i & ect_pkg::MODE_WR_MASK;
            if (wr_i && addr_i == ect_pkg::ADDR_RUN)
                run_control_reg <= wdata_i[ect_pkg::RUN_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_o <= 16'h0000;
        else if (rd_i)
        begin
            case (addr_i)
                ect_pkg::ADDR_COUNTER: rdata_o <= counter_reload_reg;
                ect_pkg::ADDR_MODE:    rdata_o <= channel_mode_reg;
                ect_pkg::ADDR_RUN:     rdata_o <= {11'h000, run_control_reg};
                ect_pkg::ADDR_STATUS:
                    rdata_o <= {12'h000, index_pend_reg,
                                state_reg == ect_pkg::ST_COUNT,
                                pulse_reg, aux_io_pin_i};
                default:               rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end

    // ------------------------------------------------------------
    // aux pin, overflow and interrupt request
    // ------------------------------------------------------------
    always_comb
    begin
        if (!run)
            pulse_next = 1'b0;
        else if (wrap)
            pulse_next = ~pulse_reg;
        else
            pulse_next = pulse_reg;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pulse_reg         <= 1'b0;
            aux_io_pin_o      <= 1'b0;
            aux_io_pin_oe_n_o <= 1'b1;
            ovf_o             <= 1'b0;
            irq_o             <= 1'b0;
        end
        else
        begin
            pulse_reg    <= pulse_next;
            aux_io_pin_o <= channel_mode_reg.pulse_en ?
                            pulse_next : channel_mode_reg.gpio_data;
            // direction input and two-phase use the pin as input
            aux_io_pin_oe_n_o <= ~(!tp_ok && !channel_mode_reg.dir_ext &&
                                   (channel_mode_reg.pulse_en ||
                                    channel_mode_reg.gpio_out));
            ovf_o        <= wrap;
            irq_o        <= wrap;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    AST_RELOAD_ON_WRAP: assert property (
        wrap && !channel_mode_reg.free_run && !wr_cnt
        |=> counter_reload_reg == $past(reload_reg))
        else $error("reload value not loaded on wrap");
    AST_FREE_OVERFLOW: assert property (
        wrap && up && channel_mode_reg.free_run
        |=> counter_reload_reg == ect_pkg::COUNT_MIN)
        else $error("free-run overflow did not wrap to zero");
    AST_FREE_UNDERFLOW: assert property (
        wrap && !up && channel_mode_reg.free_run
        |=> counter_reload_reg == ect_pkg::COUNT_MAX)
        else $error("free-run underflow did not wrap to max");
    AST_IRQ_ON_WRAP: assert property (
        wrap |=> irq_o && ovf_o)
        else $error("missing interrupt request on wrap");
    AST_NO_SPURIOUS_IRQ: assert property (
        irq_o |-> $past(wrap))
        else $error("interrupt request without wrap");
    AST_READ_LIVE: assert property (
        rd_i && addr_i == ect_pkg::ADDR_COUNTER
        |=> rdata_o == $past(counter_reload_reg))
        else $error("counter read not live value");
    AST_WRITE_STOPPED: assert property (
        wr_cnt && state_reg != ect_pkg::ST_COUNT
        |=> counter_reload_reg == $past(wdata_i) &&
            reload_reg == $past(wdata_i))
        else $error("stopped write did not load both");
    AST_WRITE_RUNNING: assert property (
        wr_cnt && state_reg == ect_pkg::ST_COUNT && !ev
        |=> $stable(counter_reload_reg) && reload_reg == $past(wdata_i))
        else $error("running write disturbed the counter");
    AST_STOPPED_HOLDS: assert property (
        !run && !wr_cnt |=> $stable(counter_reload_reg))
        else $error("counter moved while stopped");
    AST_PULSE_LOW: assert property (
        (!run && channel_mode_reg.pulse_en) [*2] |-> !aux_io_pin_o)
        else $error("pulse output not low while stopped");
    AST_PULSE_TOGGLE: assert property (
        wrap && run && channel_mode_reg.pulse_en
        |=> aux_io_pin_o == !$past(pulse_reg))
        else $error("pulse output did not toggle");
    AST_INDEX_CLEAR: assert property (
        index_hit && !wr_cnt |=> counter_reload_reg == ect_pkg::COUNT_MIN)
        else $error("index reset did not clear counter");
    COV_OVERFLOW:  cover property (wrap && up);
    COV_UNDERFLOW: cover property (wrap && !up);
    COV_INDEX:     cover property (index_hit);
    COV_RUN_WRITE: cover property (wr_cnt && state_reg == ect_pkg::ST_COUNT);
endmodule : ect_top
`default_nettype wire

// ==== hdl/ect_top_dummy_none.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/ect_enc_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ect_enc_model (
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic step_i,
    input  wire logic up_i,
    output logic      phase_a_o,
    output logic      phase_b_o
);
    logic [1:0] pos_reg;

    // ------------------------------------------------------------
    // quadrature walk, one edge per step
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pos_reg <= 2'h0;
        else if (step_i)
            pos_reg <= up_i ? pos_reg + 2'h1 : pos_reg - 2'h1;
    end

    // going up, phase a rises while b is high
    always_comb
    begin
        case (pos_reg)
            2'h0:    {phase_a_o, phase_b_o} = 2'b01;
            2'h1:    {phase_a_o, phase_b_o} = 2'b11;
            2'h2:    {phase_a_o, phase_b_o} = 2'b10;
            default: {phase_a_o, phase_b_o} = 2'b00;
        endcase
    end
endmodule : ect_enc_model

`default_nettype wire

// ==== tb/ect_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module ect_top_test;
    localparam logic [15:0] RUN_ON = 16'h0008;
    logic        clock_i = 1'b0;
    logic        rstn_i  = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [15:0] wdata   = 16'h0000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [15:0] rdata;
    logic        cnt_pin = 1'b0;
    logic        tb_aux  = 1'b0;
    logic        idx_pin = 1'b0;
    logic [2:0]  src_pls = 3'h0;
    logic        enc_sel = 1'b0;
    logic        step    = 1'b0;
    logic        up      = 1'b1;
    logic        enc_a;
    logic        enc_b;
    logic        aux_o;
    logic        aux_oe_n;
    logic        ovf;
    logic        irq;
    wire logic   cnt_w;
    wire logic   aux_w;
    int          fails      = 0;
    int          num_checks = 0;
    int          irq_seen   = 0;
    int          ovf_seen   = 0;

    // the device wins the aux wire only while it enables its driver
    assign cnt_w = enc_sel ? enc_a : cnt_pin;
    assign aux_w = !aux_oe_n ? aux_o : (enc_sel ? enc_b : tb_aux);

    ect_top ect_top_inst (
        .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .count_input_pin_i(cnt_w), .aux_io_pin_i(aux_w),
        .aux_io_pin_o(aux_o), .aux_io_pin_oe_n_o(aux_oe_n),
        .index_input_pin_i(idx_pin), .timer_b_ovf_i(src_pls[0]),
        .prev_ovf_i(src_pls[1]), .next_ovf_i(src_pls[2]),
        .ovf_o(ovf), .irq_o(irq)
    );

    ect_enc_model ect_enc_model_inst (
        .clock_i(clock_i), .rstn_i(rstn_i), .step_i(step), .up_i(up),
        .phase_a_o(enc_a), .phase_b_o(enc_b)
    );

    always #50 clock_i = ~clock_i;

    always @(posedge clock_i)
    begin
        if (irq === 1'b1)
            irq_seen <= irq_seen + 1;
        if (ovf === 1'b1)
            ovf_seen <= ovf_seen + 1;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock_i);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd   <= 1'b0;
        @(negedge clock_i);
        check(rdata, exp);
    endtask : rd_reg

    // stop first so the counter write loads both registers
    task automatic setup(input logic [15:0] mode, input logic [15:0] cnt);
        wr_reg(ect_pkg::ADDR_RUN, 16'h0000);
        wr_reg(ect_pkg::ADDR_MODE, mode);
        wr_reg(ect_pkg::ADDR_COUNTER, cnt);
        wr_reg(ect_pkg::ADDR_RUN, RUN_ON);
    endtask : setup

    task automatic edge_to(input logic v);
        @(posedge clock_i);
        cnt_pin <= v;
        repeat (2) @(posedge clock_i);
    endtask : edge_to

    task automatic pin(input int n);
        repeat (n)
        begin
            edge_to(1'b1);
            edge_to(1'b0);
        end
    endtask : pin

    task automatic enc(input int n, input logic u);
        repeat (n)
        begin
            @(posedge clock_i);
            step <= 1'b1;
            up   <= u;
            @(posedge clock_i);
            step <= 1'b0;
            repeat (2) @(posedge clock_i);
        end
    endtask : enc

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (20000) @(posedge clock_i);
        fails++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd_reg(ect_pkg::ADDR_COUNTER, ect_pkg::COUNT_RESET);
        rd_reg(ect_pkg::ADDR_MODE, ect_pkg::MODE_RESET);
        rd_reg(ect_pkg::ADDR_RUN, 16'h0000);
        rd_reg(8'h10, 16'h0000);
        check({15'h0000, aux_o}, 16'h0000);
        done("reset");
        // falling edge, software down
        setup(16'h0000, 16'h0005);
        edge_to(1'b1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0005);
        edge_to(1'b0);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0004);
        done("edge");
        setup(16'h0014, 16'hFFFE);
        pin(4);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'hFFFE);
        check(16'(irq_seen), 16'h0002);
        done("overflow");
        setup(16'h0004, 16'h0002);
        pin(1);
        wr_reg(ect_pkg::ADDR_COUNTER, 16'h0007);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0001);
        pin(2);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0007);
        check(16'(irq_seen), 16'h0003);
        done("underflow");
        setup(16'h0034, 16'hFFFF);
        pin(1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0000);
        check(16'(irq_seen), 16'h0004);
        // reload of zero tells a reload apart from a free wrap
        setup(16'h0024, 16'h0000);
        pin(1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'hFFFF);
        check(16'(irq_seen), 16'h0005);
        done("free_run");
        setup(16'h0054, 16'hFFFF);
        check({15'h0000, aux_oe_n}, 16'h0000);
        pin(1);
        check({15'h0000, aux_w}, 16'h0001);
        pin(1);
        check({15'h0000, aux_w}, 16'h0000);
        pin(1);
        check({15'h0000, aux_w}, 16'h0001);
        wr_reg(ect_pkg::ADDR_RUN, 16'h0000);
        repeat (2) @(posedge clock_i);
        check({15'h0000, aux_w}, 16'h0000);
        check(16'(irq_seen), 16'h0008);
        check(16'(ovf_seen), 16'h0008);
        done("pulse");
        setup(16'h000C, 16'h0010);
        check({15'h0000, aux_oe_n}, 16'h0001);
        pin(1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h000F);
        @(posedge clock_i);
        tb_aux <= 1'b1;
        pin(1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0010);
        wr_reg(ect_pkg::ADDR_RUN, 16'h0000);
        pin(1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0010);
        // general output low must win over the bench's high level
        wr_reg(ect_pkg::ADDR_MODE, 16'h0800);
        repeat (2) @(posedge clock_i);
        check({15'h0000, aux_oe_n}, 16'h0000);
        check({15'h0000, aux_w}, 16'h0000);
        done("direction");
        // the other two overflow sources pulse first and must be ignored
        for (int i = 0; i < 3; i++)
        begin
            setup(16'h0011 + 16'(i), 16'h0000);
            @(posedge clock_i);
            src_pls <= ~(3'h1 << i);
            @(posedge clock_i);
            src_pls <= 3'h1 << i;
            @(posedge clock_i);
            src_pls <= 3'h0;
            rd_reg(ect_pkg::ADDR_COUNTER, 16'h0001);
        end
        done("sources");
        setup(16'h0080, 16'h0010);
        enc_sel <= 1'b1;
        enc(4, 1'b1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0011);
        enc(4, 1'b0);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0010);
        done("two_phase");
        setup(16'h0180, 16'h0010);
        enc(4, 1'b1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0014);
        wr_reg(ect_pkg::ADDR_MODE, 16'h0780);
        @(posedge clock_i);
        idx_pin <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0014);
        rd_reg(ect_pkg::ADDR_STATUS, 16'h000D);
        enc(1, 1'b1);
        rd_reg(ect_pkg::ADDR_COUNTER, 16'h0000);
        check(16'(irq_seen), 16'h0008);
        done("quad_index");
        tally_and_finish();
    end
endmodule : ect_top_test

`default_nettype wire
